/* File: hw/pinmux_pkg.sv */
// Purpose: Shared constants for the port C upper pin mux block
// Assumes: Register port with one-cycle read latency, 8-bit data
// Notes:   Offsets are word indices on the plain register port
package pinmux_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] FUNC_SEL_ADDR  = 4'h0; // Alternate-select bits
   localparam logic [3:0] PORT_OUT_ADDR  = 4'h1; // Output latches
   localparam logic [3:0] PORT_OE_ADDR   = 4'h2; // Output enables
   localparam logic [3:0] PORT_PIN_ADDR  = 4'h3; // Live pin levels
   localparam logic [3:0] CPU_CTRL_ADDR  = 4'h4; // Clock out, suspend
   localparam logic [3:0] IRQ_STAT_ADDR  = 4'h5; // Sticky events, W1C
   localparam logic [3:0] IRQ_MASK_ADDR  = 4'h6; // Interrupt mask
   localparam logic [3:0] T1_COUNT_ADDR  = 4'h7; // Timer 1 count
   // ==========================================================
   // Field positions
   localparam int SEL_T1_BIT    = 0; // Bit 5 as timer 1 input
   localparam int SEL_WR_BIT    = 1; // Bit 6 as write strobe
   localparam int SEL_RD_BIT    = 2; // Bit 7 as read strobe
   localparam int CTL_CLKOE_BIT = 0; // Clock output enable
   localparam int CTL_CTSEL_BIT = 1; // Timer 1 counter select
   localparam int CTL_SUSP_BIT  = 2; // Suspend request
   localparam int CTL_SPEED_BIT = 3; // Speed select, read only
   localparam int CTL_ASLP_BIT  = 4; // Suspended state, read only
   localparam int EV_WAKE_BIT   = 0; // Remote wake event
   // ==========================================================
   // Reset values
   localparam logic [7:0] FUNC_SEL_RST = 8'h00;
   localparam logic [7:0] CPU_CTRL_RST = 8'h01;
   localparam logic [7:0] PORT_RST     = 8'h00;
endpackage : pinmux_pkg

/* File: hw/port_c_upper_pin_mux.sv */
// Purpose: Function selection of port C bits 5..7, clock output,
//          remote wake, speed select and board-test float
// Assumes: All pins synchronous to SYS_CLK; PLL lives outside
// Notes:   Two-way pins are split into in, out and enable
//
// Contract
// R1: Bit 5 is port bit or timer input
// R2: Timer counts pin only with counter select
// R3: Bit 6 is port bit or write strobe
// R4: Bit 7 is port bit or read strobe
// R5: Board pulls up strobes in use
// R6: Clock output 24 MHz, gated by enable
// R7: Reduced-speed mode gives 12 MHz clock output
// R8: Wake falling edge in suspend restarts, interrupts
// R9: Wake held low blocks suspend entry
// R10: Speed input high 12 MHz, low 24
// R11: Board-test high floats every functional pin
// R12: Port pin driven only when enabled
// R13: Live pin level always readable
// R14: Reset clears alternate selects, pins inputs
`timescale 1ns/1ps
`default_nettype none
module port_c_upper_pin_mux
   import pinmux_pkg::*;
#(
   parameter int NPINS = 3
)(
   // Clock and reset
   input  wire logic             SYS_CLK,
   input  wire logic             RST,
   // Register port
   input  wire logic [3:0]       REG_ADDR,
   input  wire logic [7:0]       REG_WDATA,
   input  wire logic             REG_WR,
   input  wire logic             REG_RD,
   output logic      [7:0]       REG_RDATA,
   // Port C bits 5..7 pins
   input  wire logic [NPINS-1:0] PC_IN,
   output logic      [NPINS-1:0] PC_OUT,
   output logic      [NPINS-1:0] PC_OE,
   // External memory strobes from the core, active low
   input  wire logic             MEM_WR_N,
   input  wire logic             MEM_RD_N,
   // Clocks: 24 MHz and 12 MHz phase-locked references
   input  wire logic             PLL_FAST_CLOCK_OUTPUT,
   input  wire logic             PLL_CLK12,
   output logic                  FAST_CLOCK_OUTPUT,
   output logic                  FAST_CLOCK_OUTPUT_OE,
   input  wire logic             REDUCED_SPEED_MODE,
   // Misc pins
   input  wire logic             WAKEUP_N,
   input  wire logic             CPU_SPEED_SELECT,
   input  wire logic             BOARD_TEST,
   // Processor side
   output logic                  CPU_SLOW,
   output logic                  OSC_RUN,
   output logic                  TIMER1_COUNT_INPUT,
   output logic                  IRQ
);
   // ==========================================================
   // Elaboration check
   if (NPINS != 3)
   begin : g_bad_npins
      $error("NPINS must be 3 for bits 5..7");
   end

   // ==========================================================
   // State
   typedef enum logic [0:0] {RUNNING, SUSPENDED} pwr_e;
   pwr_e        pwr_q, pwr_d;
   logic [7:0]  sel_q;
   logic [7:0]  out_q;
   logic [7:0]  oe_q;
   logic [7:0]  ctl_q;
   logic [7:0]  stat_q;
   logic [7:0]  mask_q;
   logic [7:0]  t1cnt_q;
   logic [7:0]  rdata_q;
   logic        wake_prev_q;
   logic        t1_prev_q;

   // ==========================================================
   // Write decode
   wire wr_sel  = REG_WR && (REG_ADDR == FUNC_SEL_ADDR);
   wire wr_out  = REG_WR && (REG_ADDR == PORT_OUT_ADDR);
   wire wr_oe   = REG_WR && (REG_ADDR == PORT_OE_ADDR);
   wire wr_ctl  = REG_WR && (REG_ADDR == CPU_CTRL_ADDR);
   wire wr_stat = REG_WR && (REG_ADDR == IRQ_STAT_ADDR);
   wire wr_mask = REG_WR && (REG_ADDR == IRQ_MASK_ADDR);
   wire wr_t1   = REG_WR && (REG_ADDR == T1_COUNT_ADDR);

   // ==========================================================
   // Per-pin mux: alternate function or port latch
   wire [NPINS-1:0] alt_sel;
   wire [NPINS-1:0] alt_drv;
   wire [NPINS-1:0] alt_val;
   assign alt_sel = {sel_q[SEL_RD_BIT], sel_q[SEL_WR_BIT],
                     sel_q[SEL_T1_BIT]};
   // Timer pin is an input, so it never drives
   assign alt_drv = {sel_q[SEL_RD_BIT], sel_q[SEL_WR_BIT], 1'b0};
   assign alt_val = {MEM_RD_N, MEM_WR_N, 1'b0};

   genvar i;
   for (i = 0; i < NPINS; i++)
   begin : g_pin
      // Alternate wins; port drives only with its enable
      assign PC_OUT[i] = alt_sel[i] ? alt_val[i]
                                    : out_q[5+i];      // R1 R3 R4
      assign PC_OE[i]  = !BOARD_TEST &&                // R11
                         (alt_sel[i] ? alt_drv[i]
                                     : oe_q[5+i]);     // R12
   end

   // Strobes idle high; pull-ups cover reset before selection
   // are the board's job, we rely on them                 R5

   // ==========================================================
   // Timer 1 input path
   wire t1_pin  = sel_q[SEL_T1_BIT] && PC_IN[0];            // R1
   wire t1_use  = t1_pin && ctl_q[CTL_CTSEL_BIT];           // R2
   wire t1_fall = t1_prev_q && !t1_use;
   assign TIMER1_COUNT_INPUT = t1_use;

   // ==========================================================
   // Clock output and speed
   assign FAST_CLOCK_OUTPUT = !ctl_q[CTL_CLKOE_BIT] ? 1'b0   // R6
                            : REDUCED_SPEED_MODE ? PLL_CLK12 // R7
                            : PLL_FAST_CLOCK_OUTPUT;                     // R6
   assign FAST_CLOCK_OUTPUT_OE = ctl_q[CTL_CLKOE_BIT] && !BOARD_TEST;
   assign CPU_SLOW = CPU_SPEED_SELECT;                       // R10

   // ==========================================================
   // Power state: wake edge and suspend blocking
   wire wake_fall = wake_prev_q && !WAKEUP_N;
   wire susp_req  = wr_ctl && REG_WDATA[CTL_SUSP_BIT];
   always_comb
   begin
      pwr_d = pwr_q;
      case (pwr_q)
         RUNNING:
         begin
            if (susp_req && WAKEUP_N)                        // R9
               pwr_d = SUSPENDED;
         end
         SUSPENDED:
         begin
            if (wake_fall)                                   // R8
               pwr_d = RUNNING;
         end
         default: pwr_d = RUNNING;
      endcase
   end
   assign OSC_RUN = (pwr_q == RUNNING);                      // R8

   // Wake event sets status; set beats a same-cycle clear
   wire        wake_ev = (pwr_q == SUSPENDED) && wake_fall;  // R8
   wire [7:0]  stat_d  = (stat_q & ~(wr_stat ? REG_WDATA : 8'h00))
                         | {7'h00, wake_ev};
   assign IRQ = |(stat_q & mask_q);                          // R8

   // ==========================================================
   // Read mux
   wire [7:0] pin_view = {PC_IN, 5'h00};                    // R13
   wire [7:0] ctl_view = {3'h0,
                          pwr_q == SUSPENDED,
                          CPU_SPEED_SELECT,
                          1'b0,
                          ctl_q[CTL_CTSEL_BIT],
                          ctl_q[CTL_CLKOE_BIT]};
   logic [7:0] rd_mux;
   always_comb
   begin
      if (REG_ADDR == FUNC_SEL_ADDR)      rd_mux = sel_q;
      else if (REG_ADDR == PORT_OUT_ADDR) rd_mux = out_q;
      else if (REG_ADDR == PORT_OE_ADDR)  rd_mux = oe_q;
      else if (REG_ADDR == PORT_PIN_ADDR) rd_mux = pin_view;
      else if (REG_ADDR == CPU_CTRL_ADDR) rd_mux = ctl_view;
      else if (REG_ADDR == IRQ_STAT_ADDR) rd_mux = stat_q;
      else if (REG_ADDR == IRQ_MASK_ADDR) rd_mux = mask_q;
      else if (REG_ADDR == T1_COUNT_ADDR) rd_mux = t1cnt_q;
      else                                rd_mux = 8'h00;
   end
   assign REG_RDATA = rdata_q;

   // ==========================================================
   // Configuration registers
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         sel_q  <= FUNC_SEL_RST;                             // R14
         out_q  <= PORT_RST;
         oe_q   <= PORT_RST;                                 // R14
         ctl_q  <= CPU_CTRL_RST;
         mask_q <= PORT_RST;
      end
      else
      begin
         if (wr_sel)  sel_q  <= REG_WDATA & 8'h07;
         if (wr_out)  out_q  <= REG_WDATA;
         if (wr_oe)   oe_q   <= REG_WDATA;
         if (wr_ctl)  ctl_q  <= REG_WDATA & 8'h03;
         if (wr_mask) mask_q <= REG_WDATA & 8'h01;
      end
   end

   // ==========================================================
   // Status, power, counter and read data
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         pwr_q       <= RUNNING;
         stat_q      <= 8'h00;
         t1cnt_q     <= 8'h00;
         rdata_q     <= 8'h00;
         wake_prev_q <= 1'b1;
         t1_prev_q   <= 1'b0;
      end
      else
      begin
         pwr_q       <= pwr_d;
         stat_q      <= stat_d;
         wake_prev_q <= WAKEUP_N;
         t1_prev_q   <= t1_use;
         // Count on falling edge of the external input      R2
         if (wr_t1)
            t1cnt_q <= REG_WDATA;
         else if (t1_fall)
            t1cnt_q <= t1cnt_q + 8'h01;
         rdata_q     <= REG_RD ? rd_mux : 8'h00;
      end
   end
endmodule : port_c_upper_pin_mux
`default_nettype wire

/* File: testbench/port_c_upper_pin_mux_properties.sv */
// Purpose: Port-level checks of the pin mux
// Assumes: Sees only the top module ports
// Notes:   Bound to the design below the module
`timescale 1ns/1ps
`default_nettype none
module pinmux_chk
   import pinmux_pkg::*;
#(
   parameter int NPINS = 3
)(
   // Observed ports
   input wire logic             SYS_CLK,
   input wire logic             RST,
   input wire logic [3:0]       REG_ADDR,
   input wire logic             REG_RD,
   input wire logic [7:0]       REG_RDATA,
   input wire logic [NPINS-1:0] PC_IN,
   input wire logic [NPINS-1:0] PC_OE,
   input wire logic             PLL_FAST_CLOCK_OUTPUT,
   input wire logic             PLL_CLK12,
   input wire logic             FAST_CLOCK_OUTPUT,
   input wire logic             FAST_CLOCK_OUTPUT_OE,
   input wire logic             REDUCED_SPEED_MODE,
   input wire logic             WAKEUP_N,
   input wire logic             CPU_SPEED_SELECT,
   input wire logic             BOARD_TEST,
   input wire logic             CPU_SLOW,
   input wire logic             OSC_RUN,
   input wire logic             TIMER1_COUNT_INPUT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // ==========================================================
   // Properties
   property p_float; BOARD_TEST |-> !PC_OE && !FAST_CLOCK_OUTPUT_OE; endproperty
   a_float: assert property (p_float) else $error("pins driven in test");
   property p_clk; FAST_CLOCK_OUTPUT_OE |-> FAST_CLOCK_OUTPUT ==
      (REDUCED_SPEED_MODE ? PLL_CLK12 : PLL_FAST_CLOCK_OUTPUT); endproperty
   a_clk: assert property (p_clk) else $error("wrong clock out");
   property p_slow; CPU_SLOW == CPU_SPEED_SELECT; endproperty
   a_slow: assert property (p_slow) else $error("speed mismatch");
   property p_wake; !OSC_RUN && $fell(WAKEUP_N) |-> ##[1:2] OSC_RUN; endproperty
   a_wake: assert property (p_wake) else $error("no wake restart");
   property p_hold; !WAKEUP_N && OSC_RUN |=> OSC_RUN; endproperty
   a_hold: assert property (p_hold) else $error("suspended while held");
   property p_rst; $fell(RST) |-> PC_OE == '0; endproperty
   a_rst: assert property (p_rst) else $error("pin driven after reset");
   property p_pin; REG_RD && REG_ADDR == PORT_PIN_ADDR |=>
      REG_RDATA[7:5] == $past(PC_IN); endproperty
   a_pin: assert property (p_pin) else $error("pin level misread");
   property p_t1; TIMER1_COUNT_INPUT |-> PC_IN[0]; endproperty
   a_t1: assert property (p_t1) else $error("timer input not pin");
endmodule : pinmux_chk
bind port_c_upper_pin_mux pinmux_chk #(.NPINS(NPINS)) i_pinmux_chk (.*);
`default_nettype wire

/* File: testbench/pin_board_model.sv */
// Purpose: Board side of port C pins 5..7
// Assumes: Bench drives only pins the mux leaves free
// Notes:   Strobe pins float high through pull-ups
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
   // Mux side
   input  wire logic       clk,
   input  wire logic [2:0] pc_out,
   input  wire logic [2:0] pc_oe,
   // Bench control
   input  wire logic [2:0] ext_en,
   input  wire logic [2:0] ext_val,
   // Resolved levels
   output logic      [2:0] pc_in
);
   logic flt_q = 1'b0;
   // Free timer pin wanders, so a stale level cannot pass
   always_ff @(posedge clk) flt_q <= ~flt_q;
   // Wire level from all drivers
   assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_en & ext_val)
                | (~pc_oe & ~ext_en & {2'b11, flt_q});
endmodule : pin_board_model
`default_nettype wire

/* File: testbench/tb_port_c_upper_pin_mux.sv */
// Purpose: Self-checking bench for the port C upper pin mux
// Assumes: 125 MHz clock, reset held 12 cycles
// Notes:   Random pin traffic from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_port_c_upper_pin_mux
   import pinmux_pkg::*;
();
   logic       clk = 0, rst = 1, wr = 0, rd = 0, wr_n = 1, rd_n = 1;
   logic       c24 = 0, c12 = 0, rsm = 0, wake_n = 1, spd = 0, bt = 0;
   logic [3:0] addr = 0;
   logic [7:0] wdata = 0, rdata;
   logic [2:0] pc_in, pc_out, pc_oe, ext_val = 0, o, e;
   logic [2:0] ext_en = 3'h0;
   logic       fco, fcoe, slow, osc, t1, irq;
   int         n_errors = 0, compares = 0, seed = 63;
   // ==========================================================
   // Clocks; core strobes and PLL clocks wander each cycle
   always #4 clk = ~clk;
   always @(posedge clk) {c24, c12, wr_n, rd_n} <= 4'($random(seed));
   port_c_upper_pin_mux i_port_c_upper_pin_mux (.SYS_CLK(clk), .RST(rst),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdata), .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe),
      .MEM_WR_N(wr_n), .MEM_RD_N(rd_n), .PLL_FAST_CLOCK_OUTPUT(c24), .PLL_CLK12(c12),
      .FAST_CLOCK_OUTPUT(fco), .FAST_CLOCK_OUTPUT_OE(fcoe),
      .REDUCED_SPEED_MODE(rsm), .WAKEUP_N(wake_n), .CPU_SPEED_SELECT(spd),
      .BOARD_TEST(bt), .CPU_SLOW(slow), .OSC_RUN(osc),
      .TIMER1_COUNT_INPUT(t1), .IRQ(irq));
   pin_board_model i_pin_board_model (.clk(clk), .pc_out(pc_out),
      .pc_oe(pc_oe), .ext_en(ext_en), .ext_val(ext_val), .pc_in(pc_in));
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [7:0] s, input logic [7:0] x);
      compares++;
      if (s !== x)
      begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(rdata, x);
   endtask : rreg
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   task automatic tally_and_finish;
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rreg(FUNC_SEL_ADDR, FUNC_SEL_RST);
      chk(8'(pc_oe), 8'h00);
      // Nobody drives the strobe pins yet, pull-ups hold them idle
      chk(8'(pc_in[2:1]), 8'h03);
      ext_en <= 3'h7;
      rreg(CPU_CTRL_ADDR, CPU_CTRL_RST);
      rreg(4'hF, 8'h00);
      // Random latch, enable and board levels
      repeat (8)
      begin
         o = 3'($random(seed));
         e = 3'($random(seed));
         ext_val <= 3'($random(seed));
         wreg(PORT_OUT_ADDR, {o, 5'h00});
         wreg(PORT_OE_ADDR, {e, 5'h00});
         chk(8'({pc_oe, pc_oe & pc_out}), 8'({e, e & o}));
         rreg(PORT_PIN_ADDR, {(e & o) | (~e & ext_val), 5'h00});
      end
      // Alternate functions; port enables must not leak through
      wreg(FUNC_SEL_ADDR, 8'h07);
      repeat (4)
      begin
         step;
         chk(8'({pc_oe, pc_out[2:1]}), 8'({3'b110, rd_n, wr_n}));
      end
      wreg(CPU_CTRL_ADDR, 8'h03);
      wreg(T1_COUNT_ADDR, 8'h00);
      repeat (3)
      begin
         ext_val <= 3'h1;
         repeat (2) step;
         chk(8'(t1), 8'h01);
         ext_val <= 3'h0;
         repeat (2) step;
      end
      rreg(T1_COUNT_ADDR, 8'h03);
      wreg(CPU_CTRL_ADDR, 8'h01);
      ext_val <= 3'h1;
      step;
      chk(8'(t1), 8'h00);
      // Clock output enable and rate, all four settings
      for (int m = 0; m < 4; m++)
      begin
         wreg(CPU_CTRL_ADDR, 8'(m[1]));
         rsm <= m[0];
         step;
         chk(8'({fcoe, fco}), 8'({m[1], m[1] & (m[0] ? c12 : c24)}));
      end
      bt <= 1'b1;
      wreg(PORT_OE_ADDR, 8'hE0);
      chk(8'({pc_oe, fcoe}), 8'h00);
      bt <= 1'b0;
      spd <= 1'b1;
      step;
      chk(8'(slow), 8'h01);
      // Suspend blocked, then entered, then woken
      wreg(IRQ_MASK_ADDR, 8'h01);
      wake_n <= 1'b0;
      wreg(CPU_CTRL_ADDR, 8'h05);
      step;
      chk(8'({osc, irq}), 8'h02);
      wake_n <= 1'b1;
      wreg(CPU_CTRL_ADDR, 8'h05);
      step;
      chk(8'({osc, irq}), 8'h00);
      wake_n <= 1'b0;
      repeat (2) step;
      chk(8'({osc, irq}), 8'h03);
      wreg(IRQ_MASK_ADDR, 8'h00);
      chk(8'(irq), 8'h00);
      wreg(IRQ_MASK_ADDR, 8'h01);
      chk(8'(irq), 8'h01);
      wreg(IRQ_STAT_ADDR, 8'h01);
      rreg(IRQ_STAT_ADDR, 8'h00);
      chk(8'(irq), 8'h00);
      tally_and_finish;
   end
   // Watchdog well beyond the sequence length
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      tally_and_finish;
   end
endmodule : tb_port_c_upper_pin_mux
`default_nettype wire
